// ==== rx_msg_pkg.sv ====
`default_nettype none
package rx_msg_pkg;
    // *****************************************************************
    // Message type codes
    // *****************************************************************
    localparam logic [4:0] TYPE_ERR_COR = 5'h00;
    localparam logic [4:0] TYPE_ERR_NONFATAL = 5'h01;
    localparam logic [4:0] TYPE_ERR_FATAL = 5'h02;
    localparam logic [4:0] TYPE_INTA_ASSERT = 5'h03;
    localparam logic [4:0] TYPE_INTD_DEASSERT = 5'h0a;
    localparam logic [4:0] TYPE_PM_PME = 5'h0b;
    localparam logic [4:0] TYPE_PME_TO_ACK = 5'h0c;
    localparam logic [4:0] TYPE_PME_TURN_OFF = 5'h0d;
    localparam logic [4:0] TYPE_PM_ASPM_NAK = 5'h0e;
    localparam logic [4:0] TYPE_SLOT_POWER = 5'h0f;
    localparam logic [4:0] TYPE_LTR = 5'h10;
    localparam logic [4:0] TYPE_OBFF = 5'h11;
    localparam logic [4:0] TYPE_UNLOCK = 5'h12;
    localparam logic [4:0] TYPE_VENDOR0 = 5'h13;
    localparam logic [4:0] TYPE_VENDOR1 = 5'h14;
    localparam logic [4:0] TYPE_ATS_INV_REQ = 5'h15;
    localparam logic [4:0] TYPE_ATS_INV_CPL = 5'h16;
    localparam logic [4:0] TYPE_ATS_PAGE_REQ = 5'h17;
    localparam logic [4:0] TYPE_ATS_PRG_RSP = 5'h18;
    localparam logic [4:0] TYPE_LAST_VALID = 5'h18;

    // *****************************************************************
    // Strobe lengths in cycles
    // *****************************************************************
    localparam logic [3:0] LEN_SHORT = 4'h2;
    localparam logic [3:0] LEN_OBFF = 4'h3;
    localparam logic [3:0] LEN_VENDOR_NODATA = 4'h4;
    localparam logic [3:0] LEN_SIX = 4'h6;
    localparam logic [3:0] LEN_VENDOR_DATA = 4'h8;
    localparam logic [3:0] LEN_GAP = 4'h1;

    // *****************************************************************
    // Reset values
    // *****************************************************************
    localparam logic [4:0] RESET_TYPE = 5'h00;
    localparam logic [7:0] RESET_DATA = 8'h00;
    localparam logic [3:0] RESET_COUNT = 4'h0;

    // *****************************************************************
    // Carriers
    // *****************************************************************
    typedef struct packed {
        logic [4:0] msg_type;
        logic [15:0] requester_id;
        logic [15:0] vendor_id;
        logic has_payload;
        logic [31:0] payload;
        logic [7:0] obff_code;
    } msg_desc_t;

    typedef struct packed {
        logic strobe;
        logic [4:0] msg_type;
        logic [7:0] data;
    } msg_ind_t;
endpackage : rx_msg_pkg
`default_nettype wire

// ==== rx_message_indication_port.sv ====
`default_nettype none
module rx_message_indication_port (
    // Clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // Configuration
    input wire logic enable_in,
    // Message from the link receiver
    input wire logic msg_valid_in,
    input wire rx_msg_pkg::msg_desc_t msg_in,
    output logic msg_ready_out,
    // Indication towards user logic
    output logic msg_strobe_out,
    output logic [4:0] msg_type_out,
    output logic [7:0] msg_data_out
);
    // *****************************************************************
    // State
    // *****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_GAP = 3'b100
    } state_t;

    state_t state_r, state_nxt;
    rx_msg_pkg::msg_desc_t desc_r, desc_nxt;
    rx_msg_pkg::msg_ind_t ind_r, ind_nxt;
    logic [3:0] len_r, len_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic ready_r, ready_nxt;

    // *****************************************************************
    // Strobe length by type
    // *****************************************************************
    function automatic logic [3:0] strobe_len(input rx_msg_pkg::msg_desc_t d);
        logic [3:0] len;
        len = rx_msg_pkg::LEN_SHORT;
        unique case (d.msg_type)
            rx_msg_pkg::TYPE_SLOT_POWER: len = rx_msg_pkg::LEN_SIX;
            rx_msg_pkg::TYPE_LTR: len = rx_msg_pkg::LEN_SIX;
            rx_msg_pkg::TYPE_OBFF: len = rx_msg_pkg::LEN_OBFF;
            rx_msg_pkg::TYPE_VENDOR0,
            rx_msg_pkg::TYPE_VENDOR1: begin
                len = d.has_payload ? rx_msg_pkg::LEN_VENDOR_DATA : rx_msg_pkg::LEN_VENDOR_NODATA;
            end
            default: len = rx_msg_pkg::LEN_SHORT;
        endcase
        return len;
    endfunction : strobe_len

    // *****************************************************************
    // Byte selected for a given strobe cycle
    // *****************************************************************
    function automatic logic [7:0] param_byte(input rx_msg_pkg::msg_desc_t d, input logic [3:0] idx);
        logic [7:0] b;
        b = rx_msg_pkg::RESET_DATA;
        if (idx == 4'h0) begin
            b = d.requester_id[15:8];
        end else if (idx == 4'h1) begin
            b = d.requester_id[7:0];
        end else if (d.msg_type == rx_msg_pkg::TYPE_OBFF) begin
            b = d.obff_code;
        end else if (d.msg_type == rx_msg_pkg::TYPE_VENDOR0 || d.msg_type == rx_msg_pkg::TYPE_VENDOR1) begin
            unique case (idx)
                4'h2: b = d.vendor_id[7:0];
                4'h3: b = d.vendor_id[15:8];
                4'h4: b = d.payload[7:0];
                4'h5: b = d.payload[15:8];
                4'h6: b = d.payload[23:16];
                4'h7: b = d.payload[31:24];
                default: b = rx_msg_pkg::RESET_DATA;
            endcase
        end else begin
            // LTR carries snoop then no-snoop latency in the payload word
            unique case (idx)
                4'h2: b = d.payload[7:0];
                4'h3: b = d.payload[15:8];
                4'h4: b = d.payload[23:16];
                4'h5: b = d.payload[31:24];
                default: b = rx_msg_pkg::RESET_DATA;
            endcase
        end
        return b;
    endfunction : param_byte

    // *****************************************************************
    // Next state
    // *****************************************************************
    always_comb begin
        state_nxt = state_r;
        desc_nxt = desc_r;
        len_nxt = len_r;
        idx_nxt = idx_r;
        ind_nxt = ind_r;
        ready_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                ind_nxt.strobe = 1'b0;
                if (msg_valid_in && ready_r && enable_in && msg_in.msg_type <= rx_msg_pkg::TYPE_LAST_VALID) begin
                    desc_nxt = msg_in;
                    len_nxt = strobe_len(msg_in);
                    idx_nxt = 4'h1;
                    ind_nxt.strobe = 1'b1;
                    ind_nxt.msg_type = msg_in.msg_type;
                    ind_nxt.data = param_byte(msg_in, 4'h0);
                    state_nxt = ST_SEND;
                end else begin
                    ready_nxt = 1'b1;
                end
            end
            ST_SEND: begin
                if (idx_r == len_r) begin
                    ind_nxt.strobe = 1'b0;
                    ind_nxt.data = rx_msg_pkg::RESET_DATA;
                    idx_nxt = rx_msg_pkg::RESET_COUNT;
                    state_nxt = ST_GAP;
                end else begin
                    // Type is held; only the byte changes
                    ind_nxt.data = param_byte(desc_r, idx_r);
                    idx_nxt = idx_r + 4'h1;
                end
            end
            ST_GAP: begin
                ready_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                ind_nxt.strobe = 1'b0;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // *****************************************************************
    // Registers
    // *****************************************************************
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= ST_IDLE;
            desc_r <= '0;
            len_r <= rx_msg_pkg::RESET_COUNT;
            idx_r <= rx_msg_pkg::RESET_COUNT;
            ind_r <= '0;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            desc_r <= desc_nxt;
            len_r <= len_nxt;
            idx_r <= idx_nxt;
            ind_r <= ind_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign msg_strobe_out = ind_r.strobe;
    assign msg_type_out = ind_r.msg_type;
    assign msg_data_out = ind_r.data;
    assign msg_ready_out = ready_r;
endmodule : rx_message_indication_port
`default_nettype wire

// ==== rx_msg_chk_assertions.sv ====
`default_nettype none
module rx_msg_chk (
    // Clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // Watched ports
    input wire logic enable_in,
    input wire logic msg_valid_in,
    input wire rx_msg_pkg::msg_desc_t msg_in,
    input wire logic msg_ready_out,
    input wire logic msg_strobe_out,
    input wire logic [4:0] msg_type_out,
    input wire logic [7:0] msg_data_out
);
    // ****************
    // Port checks
    // ****************
    default clocking dc @(posedge clock_in);
    endclocking
    default disable iff (!arst_n_in);
    logic take;
    logic [4:0] t;
    assign t = msg_in.msg_type;
    assign take = msg_valid_in && msg_ready_out && enable_in && t <= 5'h18;
    chk_take_answer: assert property (take |=> msg_strobe_out && msg_type_out == $past(t)
        && msg_data_out == $past(msg_in.requester_id[15:8])) else $error("bad first strobe cycle");
    chk_reserved_drop: assert property (msg_valid_in && msg_ready_out && (t > 5'h18 || !enable_in)
        |=> !msg_strobe_out) else $error("dropped message strobed");
    chk_short_len: assert property (take && (t <= 5'h0e || t == 5'h12 || t >= 5'h15)
        |=> msg_strobe_out [*2] ##1 !msg_strobe_out) else $error("short strobe length");
    chk_obff_code: assert property (take && t == 5'h11 |=> msg_strobe_out [*3]
        ##0 msg_data_out == $past(msg_in.obff_code, 3) ##1 !msg_strobe_out) else $error("obff strobe");
    chk_six_len: assert property (take && (t == 5'h0f || t == 5'h10)
        |=> msg_strobe_out [*6] ##1 !msg_strobe_out) else $error("six cycle strobe");
    chk_vendor_bare: assert property (take && (t == 5'h13 || t == 5'h14) && !msg_in.has_payload
        |=> msg_strobe_out [*4] ##1 !msg_strobe_out) else $error("vendor strobe without data");
    chk_vendor_data: assert property (take && (t == 5'h13 || t == 5'h14) && msg_in.has_payload
        |=> msg_strobe_out [*8] ##1 !msg_strobe_out) else $error("vendor strobe with data");
    chk_type_hold: assert property (msg_strobe_out && $past(msg_strobe_out) |-> $stable(msg_type_out))
        else $error("type moved in strobe");
    chk_idle_gap: assert property ($fell(msg_strobe_out) |=> !msg_strobe_out)
        else $error("no idle gap");
    cover property (take && t == 5'h0f);
    cover property (take && t == 5'h13 && msg_in.has_payload);
    cover property (take && t == 5'h11);
endmodule : rx_msg_chk
bind rx_message_indication_port rx_msg_chk rx_msg_chk_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .enable_in(enable_in), .msg_valid_in(msg_valid_in), .msg_in(msg_in), .msg_ready_out(msg_ready_out),
    .msg_strobe_out(msg_strobe_out), .msg_type_out(msg_type_out), .msg_data_out(msg_data_out));
`default_nettype wire

// ==== rx_msg_user_model.sv ====
`default_nettype none
module rx_msg_user_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic arst_n_in,
    // Indication
    input wire logic strobe_in,
    input wire logic [4:0] type_in,
    input wire logic [7:0] data_in,
    // Last message seen
    output logic [72:0] got_out,
    output int count_out
);
    // ****************
    // Collector, ready in every cycle
    // Every strobed byte is gathered, up to 8 bytes including the whole payload word
    // Issues no requests; it only watches the strobe, type and data inputs
    // ****************
    logic [63:0] bytes_r;
    logic [3:0] len_r;
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            len_r <= 4'h0;
            bytes_r <= 64'h0;
            count_out <= 0;
        end else if (strobe_in) begin
            bytes_r[8 * len_r +: 8] <= data_in;
            len_r <= len_r + 4'h1;
            got_out[72:68] <= type_in;
        end else if (len_r != 4'h0) begin
            got_out[67:0] <= {len_r, bytes_r};
            count_out <= count_out + 1;
            len_r <= 4'h0;
            bytes_r <= 64'h0;
        end
    end
endmodule : rx_msg_user_model
`default_nettype wire

// ==== rx_message_indication_port_test.sv ====
`default_nettype none
module rx_message_indication_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic enable_in = 1'b1;
    logic msg_valid_in = 1'b0;
    rx_msg_pkg::msg_desc_t msg_in = '0;
    logic msg_ready_out, msg_strobe_out;
    logic [4:0] msg_type_out;
    logic [7:0] msg_data_out;
    logic [72:0] got;
    int got_count, base, mismatches = 0, compares = 0, seed = 32'hd0b4;
    always #2.5 clock_in = ~clock_in;
    rx_message_indication_port rx_message_indication_port_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .enable_in(enable_in), .msg_valid_in(msg_valid_in), .msg_in(msg_in), .msg_ready_out(msg_ready_out),
        .msg_strobe_out(msg_strobe_out), .msg_type_out(msg_type_out), .msg_data_out(msg_data_out));
    rx_msg_user_model rx_msg_user_model_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .strobe_in(msg_strobe_out), .type_in(msg_type_out), .data_in(msg_data_out),
        .got_out(got), .count_out(got_count));
    // ****************
    // Expected type, length and bytes
    // ****************
    function automatic logic [72:0] expect_of(input rx_msg_pkg::msg_desc_t d);
        logic [63:0] b;
        logic [3:0] n;
        b = {48'h0, d.requester_id[7:0], d.requester_id[15:8]};
        n = 4'h2;
        case (d.msg_type)
            5'h0f, 5'h10: begin
                b[47:16] = d.payload;
                n = 4'h6;
            end
            5'h11: begin
                b[23:16] = d.obff_code;
                n = 4'h3;
            end
            5'h13, 5'h14: begin
                b[31:16] = d.vendor_id;
                b[63:32] = d.has_payload ? d.payload : 32'h0;
                n = d.has_payload ? 4'h8 : 4'h4;
            end
            default: ;
        endcase
        return {d.msg_type, n, b};
    endfunction : expect_of
    task automatic check(input logic [72:0] g, input logic [72:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic run(input logic [4:0] t, input logic en);
        rx_msg_pkg::msg_desc_t x;
        int i;
        x = 78'({$random(seed), $random(seed), $random(seed)});
        x.msg_type = t;
        base = got_count;
        for (i = 0; i < 20 && msg_ready_out !== 1'b1; i++) @(negedge clock_in);
        if (i == 20) begin
            mismatches++;
            tally_and_finish();
        end
        @(posedge clock_in);
        msg_valid_in <= 1'b1;
        msg_in <= x;
        enable_in <= en;
        @(posedge clock_in);
        msg_valid_in <= 1'b0;
        for (i = 0; i < 20 && got_count == base; i++) @(negedge clock_in);
        if (en && t <= 5'h18 && i == 20) begin
            mismatches++;
            tally_and_finish();
        end
        if (en && t <= 5'h18) check(got, expect_of(x));
        else check(73'(got_count - base), 73'h0);
        $display("test type %0d enable %0d done", t, en);
    endtask : run
    initial begin
        repeat (10) @(posedge clock_in);
        arst_n_in <= 1'b1;
        for (int k = 0; k < 64; k++) run(5'(k), 1'b1);
        run(5'h0f, 1'b0);
        repeat (40) run(5'($unsigned($random(seed)) % 25), 1'b1);
        tally_and_finish();
    end
endmodule : rx_message_indication_port_test
`default_nettype wire
